// ==== rtl/ext_io_ctrl.sv ====
// external control port: trigger edge, filter, go levels, done output
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module ext_io_ctrl
    import ext_io_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic measure_trigger_in,
    input wire logic startup_done,
    input wire logic meas_valid,
    input wire logic contact_pass,
    input wire logic vmon_pass,
    input wire logic open_pass,
    output logic trigger_accepted,
    output logic contact_go_out,
    output logic vmon_go_out,
    output logic open_go_out,
    output logic measurement_done_out,
    output logic index_out
);
    // clamp a millisecond setting into its legal range
    function automatic logic [LEN_W-1:0] clamp_ms(
        input logic [31:0] val,
        input logic [LEN_W-1:0] lo,
        input logic [LEN_W-1:0] hi
    );
        logic [LEN_W-1:0] res;
        res = lo;
        if (val < {23'h00_0000, lo}) begin
            res = lo;
        end else if (val > {23'h00_0000, hi}) begin
            res = hi;
        end else begin
            res = val[LEN_W-1:0];
        end
        return res;
    endfunction : clamp_ms

    logic [CTRL_W-1:0] ctrl_r; // mode bits
    logic [LEN_W-1:0] filt_ms_r; // filter response time
    logic [LEN_W-1:0] pulse_ms_r; // done pulse width
    logic [ACCEPT_CNT_W-1:0] accept_cnt_r; // accepted triggers
    logic pin_s1_r; // synchroniser stage one
    logic pin_s2_r; // synchroniser stage two
    logic on_prev_r; // on state one cycle ago
    logic qual_r; // current on interval passed the filter
    logic started_r; // start-up finished
    logic done_pend_r; // judgment presented, done due next
    logic wr_en; // apb write takes effect
    logic rd_en; // first access cycle of a read or a write; read data captured when pwrite is low
    logic addr_ok; // address maps to a register
    logic on_lvl; // trigger in its on state
    logic on_rise; // on edge
    logic on_fall; // off edge
    logic accept_now; // trigger accepted this cycle
    logic filt_busy; // filter timer running
    logic filt_exp; // filter time elapsed
    logic pulse_exp; // done pulse width elapsed
    logic [31:0] rd_mux; // read data selection

    // mode bit aliases
    wire off_edge = ctrl_r[CTRL_OFF_EDGE];
    wire sink_wiring = ctrl_r[CTRL_SINK];
    wire filt_en = ctrl_r[CTRL_FILT_EN];
    wire go_inv = ctrl_r[CTRL_GO_INV];
    wire pulse_mode = ctrl_r[CTRL_PULSE_MODE];
    wire cc_en = ctrl_r[CTRL_CC_EN];

    // apb decode; one wait state so all outputs come from flip-flops
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && !pready;
    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFF_CTRL: rd_mux = {26'h000_0000, ctrl_r};
            OFF_FILT: rd_mux = {23'h00_0000, filt_ms_r};
            OFF_PULSE: rd_mux = {23'h00_0000, pulse_ms_r};
            OFF_STATUS: rd_mux = {24'h00_0000, started_r, qual_r,
                filt_busy, index_out, measurement_done_out,
                vmon_go_out, contact_go_out, on_lvl};
            OFF_ACCEPT_CNT: rd_mux = {16'h0000, accept_cnt_r};
            default: addr_ok = 1'b0;
        endcase
    end

    // apb handshake and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= rd_en;
            pslverr <= rd_en && !addr_ok;
            if (rd_en && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // configuration registers; out-of-range times are clamped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
            filt_ms_r <= FILT_MS_RST;
            pulse_ms_r <= PULSE_MS_RST;
        end else if (wr_en) begin
            case (paddr)
                OFF_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
                OFF_FILT: filt_ms_r <= clamp_ms(pwdata, FILT_MS_MIN,
                    FILT_MS_MAX);
                OFF_PULSE: pulse_ms_r <= clamp_ms(pwdata, PULSE_MS_MIN,
                    PULSE_MS_MAX);
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // two-flop synchroniser on the trigger pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= measure_trigger_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // on state by wiring: sink wiring pulls the pin low when on
    assign on_lvl = sink_wiring ? !pin_s2_r : pin_s2_r;
    assign on_rise = on_lvl && !on_prev_r;
    assign on_fall = !on_lvl && on_prev_r;

    // filter timer restarts on each on edge and aborts on drop
    ms_interval_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_filt_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .start(on_rise && filt_en),
        .abort(!on_lvl || !filt_en),
        .len_ms(filt_ms_r),
        .busy(filt_busy),
        .expired(filt_exp)
    );

    // qualified flag lasts for the rest of the on interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_prev_r <= 1'b0;
            qual_r <= 1'b0;
        end else begin
            on_prev_r <= on_lvl;
            if (!on_lvl) begin
                qual_r <= 1'b0;
            end else if (filt_exp) begin
                qual_r <= 1'b1;
            end
        end
    end

    // trigger acceptance by edge choice and filter state
    always_comb begin
        accept_now = 1'b0;
        if (!started_r) begin
            accept_now = 1'b0;
        end else if (!filt_en) begin
            accept_now = off_edge ? on_fall : on_rise;
        end else if (!off_edge) begin
            accept_now = filt_exp && on_lvl;
        end else begin
            // off edge only after a qualified on interval
            accept_now = on_fall && qual_r;
        end
    end

    // accepted trigger pulse and count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_accepted <= 1'b0;
            accept_cnt_r <= '0;
        end else begin
            trigger_accepted <= accept_now;
            if (accept_now) begin
                accept_cnt_r <= accept_cnt_r + ACCEPT_CNT_W'(1);
            end
        end
    end

    // judgment outputs latched with each measurement result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contact_go_out <= 1'b0;
            vmon_go_out <= 1'b0;
            open_go_out <= 1'b0;
        end else if (meas_valid && started_r) begin
            // disabled check always reads off: a fail with normal go levels, a pass when inverted
            contact_go_out <= cc_en && (contact_pass ^ go_inv);
            vmon_go_out <= vmon_pass ^ go_inv;
            open_go_out <= open_pass;
        end
    end

    // done pulse width timer, started as done turns on
    ms_interval_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_pulse_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .start(done_pend_r && pulse_mode),
        .abort(trigger_accepted || !pulse_mode),
        .len_ms(pulse_ms_r),
        .busy(),
        .expired(pulse_exp)
    );

    // done and index sequencing: start-up, trigger, judgment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started_r <= 1'b0;
            done_pend_r <= 1'b0;
            measurement_done_out <= 1'b0;
            index_out <= 1'b0;
        end else begin
            done_pend_r <= meas_valid && started_r;
            if (!started_r) begin
                if (startup_done) begin
                    started_r <= 1'b1;
                    measurement_done_out <= 1'b1;
                    index_out <= 1'b1;
                end
            end else if (done_pend_r) begin
                // judgment is already stable on the go outputs
                measurement_done_out <= 1'b1;
            end else if (trigger_accepted) begin
                // hold mode keeps done on until here
                measurement_done_out <= 1'b0;
                index_out <= 1'b0;
            end else if (pulse_exp) begin
                measurement_done_out <= 1'b0;
            end
            if (started_r && meas_valid) begin
                index_out <= 1'b1;
            end
        end
    end

    // helper: consecutive cycles spent in the on state
    logic [31:0] on_run_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_run_r <= 32'h0000_0000;
        end else if (!on_lvl) begin
            on_run_r <= 32'h0000_0000;
        end else if (on_run_r != 32'hffff_ffff) begin
            on_run_r <= on_run_r + 32'h0000_0001;
        end
    end

    // helper: an accept was already seen in this on interval
    logic acc_seen_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_seen_r <= 1'b0;
        end else if (!on_lvl) begin
            acc_seen_r <= 1'b0;
        end else if (trigger_accepted) begin
            acc_seen_r <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_on_edge;
        (started_r && !filt_en && !off_edge && on_rise) |=> trigger_accepted;
    endproperty
    a_on_edge: assert property (p_on_edge)
        else $error("on edge did not start a measurement");

    property p_off_edge;
        (started_r && !filt_en && off_edge && on_fall)
            |=> trigger_accepted && !on_lvl;
    endproperty
    a_off_edge: assert property (p_off_edge)
        else $error("off edge did not start a measurement");

    property p_wiring;
        (!sink_wiring && !$past(pin_s2_r) && pin_s2_r) ##1 1'b1
            |-> $past(on_rise);
    endproperty
    a_wiring: assert property (p_wiring)
        else $error("source wiring rising edge not seen as on edge");

    property p_filter_hold;
        (trigger_accepted && $past(filt_en) && !$past(off_edge))
            |-> on_run_r >= 32'($past(filt_ms_r)) * 32'(MS_CYCLES);
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("filtered trigger accepted too early");

    property p_filt_range;
        filt_ms_r >= FILT_MS_MIN && filt_ms_r <= FILT_MS_MAX
            && pulse_ms_r >= PULSE_MS_MIN && pulse_ms_r <= PULSE_MS_MAX;
    endproperty
    a_filt_range: assert property (p_filt_range)
        else $error("millisecond setting out of range");

    property p_one_per_on;
        (acc_seen_r && on_lvl && filt_en) |-> !trigger_accepted;
    endproperty
    a_one_per_on: assert property (p_one_per_on)
        else $error("second trigger in one on interval");

    property p_go_level;
        (meas_valid && started_r && cc_en)
            |=> contact_go_out == ($past(contact_pass) ^ $past(go_inv));
    endproperty
    a_go_level: assert property (p_go_level)
        else $error("contact pass output level wrong");

    property p_vmon_open;
        (meas_valid && started_r) |=> vmon_go_out ==
            ($past(vmon_pass) ^ $past(go_inv)) && open_go_out ==
            $past(open_pass);
    endproperty
    a_vmon_open: assert property (p_vmon_open)
        else $error("voltage or open pass output level wrong");

    property p_cc_off;
        (meas_valid && started_r && !cc_en) |=> !contact_go_out;
    endproperty
    a_cc_off: assert property (p_cc_off)
        else $error("contact pass on while check disabled");

    property p_hold;
        (measurement_done_out && !pulse_mode && !trigger_accepted)
            |=> measurement_done_out;
    endproperty
    a_hold: assert property (p_hold)
        else $error("done dropped in hold mode without trigger");

    property p_pulse_end;
        (pulse_exp && !done_pend_r && !trigger_accepted)
            |=> !measurement_done_out;
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("done still on after pulse width");

    property p_startup;
        (!started_r && startup_done)
            |=> measurement_done_out && index_out;
    endproperty
    a_startup: assert property (p_startup)
        else $error("done and index not on after start-up");

    property p_done_after_judge;
        (meas_valid && started_r) |-> ##2 measurement_done_out;
    endproperty
    a_done_after_judge: assert property (p_done_after_judge)
        else $error("done late after judgment");
endmodule : ext_io_ctrl

// ==== rtl/ext_io_pkg.sv ====
// constants and register map for the external control port logic
package ext_io_pkg;
    // apb byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_FILT = 12'h004;
    localparam logic [11:0] OFF_PULSE = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_ACCEPT_CNT = 12'h010;
    // control register field positions
    localparam int CTRL_OFF_EDGE = 0;
    localparam int CTRL_SINK = 1;
    localparam int CTRL_FILT_EN = 2;
    localparam int CTRL_GO_INV = 3;
    localparam int CTRL_PULSE_MODE = 4;
    localparam int CTRL_CC_EN = 5;
    localparam int CTRL_W = 6;
    // control reset: on edge, source, no filter, normal, hold, check on
    localparam logic [5:0] CTRL_RST = 6'h20;
    // millisecond settings
    localparam int LEN_W = 9;
    localparam logic [8:0] FILT_MS_MIN = 9'h001;
    localparam logic [8:0] FILT_MS_MAX = 9'h1f4;
    localparam logic [8:0] FILT_MS_RST = 9'h001;
    localparam logic [8:0] PULSE_MS_MIN = 9'h001;
    localparam logic [8:0] PULSE_MS_MAX = 9'h064;
    localparam logic [8:0] PULSE_MS_RST = 9'h001;
    // time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int CYC_W = 17;
    // longest judgment to done delay
    localparam int DONE_DELAY_US = 100;
    localparam int DONE_DELAY_CYC = (DONE_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int ACCEPT_CNT_W = 16;
endpackage : ext_io_pkg

// ==== rtl/ms_interval_timer.sv ====
// millisecond interval timer with start and abort
`timescale 1ns/1ps
module ms_interval_timer
    import ext_io_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    input wire logic [LEN_W-1:0] len_ms,
    output logic busy,
    output logic expired
);
    logic [CYC_W-1:0] cyc_cnt_r; // cycles within current millisecond
    logic [LEN_W-1:0] ms_cnt_r; // whole milliseconds elapsed

    // count cycles, then milliseconds; expiry is a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            expired <= 1'b0;
            cyc_cnt_r <= '0;
            ms_cnt_r <= '0;
        end else begin
            expired <= 1'b0;
            if (abort) begin
                // abort wins over everything
                busy <= 1'b0;
            end else if (start) begin
                busy <= 1'b1;
                cyc_cnt_r <= '0;
                ms_cnt_r <= '0;
            end else if (busy) begin
                if (cyc_cnt_r == CYC_W'(MS_CYCLES - 1)) begin
                    cyc_cnt_r <= '0;
                    if (ms_cnt_r == len_ms - LEN_W'(1)) begin
                        busy <= 1'b0;
                        expired <= 1'b1;
                    end else begin
                        ms_cnt_r <= ms_cnt_r + LEN_W'(1);
                    end
                end else begin
                    cyc_cnt_r <= cyc_cnt_r + CYC_W'(1);
                end
            end
        end
    end
endmodule : ms_interval_timer

// ==== dv/ext_io_plc_model.sv ====
// controller model: drives the trigger pin, reads results after done
`timescale 1ns/1ps
module ext_io_plc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sink,
    input wire logic pulse_req,
    input wire logic [7:0] pulse_len,
    input wire logic done,
    input wire logic contact_go,
    input wire logic vmon_go,
    input wire logic open_go,
    output logic measure_trigger_in,
    output logic [2:0] read_go
);
    logic on_r; // trigger contact closed
    logic [7:0] left_r; // cycles of closure still to go
    logic done_r; // done seen last cycle

    // idle pin sits at the off level of the chosen wiring
    assign measure_trigger_in = sink ? !on_r : on_r;

    // closes the contact for pulse_len cycles on request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_r <= 1'b0;
            left_r <= 8'h00;
        end else if (pulse_req) begin
            on_r <= 1'b1;
            left_r <= pulse_len - 8'h01;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end else begin
            on_r <= 1'b0;
        end
    end

    // judgment is taken only once done has turned on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            read_go <= 3'b000;
        end else begin
            done_r <= done;
            if (done && !done_r) begin
                read_go <= {open_go, vmon_go, contact_go};
            end
        end
    end
endmodule : ext_io_plc_model

// ==== dv/test_ext_io_ctrl.sv ====
// self-checking bench for the external control port logic
`timescale 1ns/1ps
module test_ext_io_ctrl;
    import ext_io_pkg::*;
    localparam int MSC = 10; // shortened millisecond
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic tpin, startup_done, meas_valid, cp, vp, op, acc;
    logic cgo, vgo, ogo, done, index, sink, preq, err;
    logic [7:0] plen;
    logic [2:0] read_go;
    int miscompares, samples_checked, cyc, first, cnt;

    ext_io_ctrl #(.MS_CYCLES(MSC)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .measure_trigger_in(tpin),
        .startup_done(startup_done), .meas_valid(meas_valid),
        .contact_pass(cp), .vmon_pass(vp), .open_pass(op),
        .trigger_accepted(acc), .contact_go_out(cgo), .vmon_go_out(vgo),
        .open_go_out(ogo), .measurement_done_out(done), .index_out(index));
    ext_io_plc_model u_plc (.pclk(pclk), .presetn(presetn), .sink(sink),
        .pulse_req(preq), .pulse_len(plen), .done(done),
        .contact_go(cgo), .vmon_go(vgo), .open_go(ogo),
        .measure_trigger_in(tpin), .read_go(read_go));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends this wait for reads and writes; the hang guard ends it if pready never comes
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // closes the trigger for len cycles and logs accepted triggers
    task automatic pulse(input logic [7:0] len);
        first = -1;
        cnt = 0;
        preq <= 1'b1;
        plen <= len;
        @(posedge pclk);
        preq <= 1'b0;
        for (int i = 1; i < len + 20; i++) begin
            @(posedge pclk);
            if (acc === 1'b1) begin
                cnt++;
                if (first < 0) first = i;
            end
        end
    endtask : pulse

    task automatic test_regs_startup;
        apb(1'b0, OFF_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0020);
        apb(1'b0, OFF_FILT, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        apb(1'b0, OFF_PULSE, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        check({done, index}, 32'h0000_0000);
        startup_done <= 1'b1;
        repeat (3) @(posedge pclk);
        check({done, index}, 32'h0000_0003);
        $display("test_regs_startup done");
    endtask : test_regs_startup

    // every edge choice under both wirings, one accept per closure
    task automatic test_edges;
        for (int m = 0; m < 4; m++) begin
            sink <= m[1];
            apb(1'b1, OFF_CTRL, 32'h0000_0020 | 32'(m));
            repeat (10) @(posedge pclk);
            pulse(8'h14);
            check(cnt, 1);
            check(first > (m[0] ? 20 : 2) && first < (m[0] ? 30 : 10), 1);
            check({done, index}, 32'h0000_0000);
        end
        $display("test_edges done");
    endtask : test_edges

    // filter: short closure refused, long one accepted once
    task automatic test_filter;
        sink <= 1'b0;
        apb(1'b1, OFF_FILT, 32'h0000_0000);
        apb(1'b0, OFF_FILT, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        apb(1'b1, OFF_FILT, 32'h0000_0258);
        apb(1'b0, OFF_FILT, 32'h0000_0000);
        check(rd, 32'h0000_01f4);
        apb(1'b1, OFF_FILT, 32'h0000_0002);
        apb(1'b1, OFF_CTRL, 32'h0000_0024);
        repeat (5) @(posedge pclk);
        pulse(8'h0f);
        check(cnt, 0);
        pulse(8'h28);
        check(cnt, 1);
        check(first > 2 * MSC && first < 2 * MSC + 10, 1);
        apb(1'b0, OFF_ACCEPT_CNT, 32'h0000_0000);
        check(rd, 32'h0000_0005);
        $display("test_filter done");
    endtask : test_filter

    // go levels for each pass value and inversion, then check disabled
    task automatic test_go;
        logic [2:0] exp;
        logic p;
        for (int m = 0; m < 5; m++) begin
            // disabled check gets a passing input so gating is seen
            p = m[0] | m[2];
            apb(1'b1, OFF_CTRL, m[2] ? 32'h0 : 32'h20 | 32'(m[1]) << 3);
            {cp, vp, op, meas_valid} <= {{3{p}}, 1'b1};
            @(posedge pclk);
            meas_valid <= 1'b0;
            repeat (2) @(posedge pclk);
            exp = {p, {2{p ^ m[1]}} & {1'b1, !m[2]}};
            check({ogo, vgo, cgo}, exp);
            check(cgo, m[2] ? 1'b0 : p ^ m[1]);
            check(done, 1'b1);
            repeat (30) @(posedge pclk);
            check(read_go, exp);
            check(done, 1'b1);
            pulse(8'h03);
        end
        $display("test_go done");
    endtask : test_go

    // pulse mode: done stands pulse width plus one cycle
    task automatic test_pulse;
        apb(1'b1, OFF_PULSE, 32'h0000_00c8);
        apb(1'b0, OFF_PULSE, 32'h0000_0000);
        check(rd, 32'h0000_0064);
        apb(1'b1, OFF_PULSE, 32'h0000_0002);
        apb(1'b1, OFF_CTRL, 32'h0000_0030);
        meas_valid <= 1'b1;
        @(posedge pclk);
        meas_valid <= 1'b0;
        cnt = 0;
        repeat (60) begin
            @(posedge pclk);
            cnt += done;
        end
        check(cnt, 2 * MSC + 1);
        $display("test_pulse done");
    endtask : test_pulse

    task automatic test_done;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        {psel, penable, pwrite, startup_done, meas_valid} = 5'b0;
        {cp, vp, op, sink, preq} = 5'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        plen = 8'h00;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_regs_startup();
        test_edges();
        test_filter();
        test_go();
        test_pulse();
        test_done();
    end
endmodule : test_ext_io_ctrl
